// [logic/atbc_defs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef ATBC_DEFS_SVH
`define ATBC_DEFS_SVH

`define ATBC_OFF_CTRL0      8'h00
`define ATBC_OFF_CTRL1      8'h04
`define ATBC_OFF_TRIG       8'h08
`define ATBC_OFF_DELAY      8'h0C
`define ATBC_OFF_BGREF      8'h10
`define ATBC_OFF_LO_HB      8'h14
`define ATBC_OFF_LO_LB      8'h18
`define ATBC_OFF_HI_HB      8'h1C
`define ATBC_OFF_HI_LB      8'h20
`define ATBC_OFF_RESULT     8'h24
`define ATBC_OFF_IRQ_STAT   8'h28
`define ATBC_OFF_IRQ_EN     8'h2C

`define ATBC_C0_START       7
`define ATBC_C0_BUSY        6
`define ATBC_C0_PWR         5
`define ATBC_C0_FMT         4
`define ATBC_TR_SRC         7
`define ATBC_TR_DLY_EN      6
`define ATBC_TR_PWM_SRC     5
`define ATBC_TR_CMP_HI      4
`define ATBC_TR_CMP_LO      3
`define ATBC_IRQ_EOC        0
`define ATBC_IRQ_CMP        1

`define ATBC_RST_BYTE       8'h00
`define ATBC_RST_DIV        3'h0
`define ATBC_SAMPLE_PERIODS 4'h4
`define ATBC_LAST_PERIOD    4'hF
`define ATBC_TOTAL_PERIODS  12'h010

`endif

// [logic/atbc_pkg.sv]
// Types shared by the converter trigger and boundary control block
package atbc_pkg;

	typedef enum logic [0:0] {SEQ_IDLE, SEQ_RUN} atbc_seq_t;
	typedef enum logic [0:0] {TRIG_IDLE, TRIG_DELAY} atbc_trig_t;

	typedef struct packed {
		atbc_seq_t  st;
		logic [7:0] pre;
		logic [3:0] per;
		logic       busy;
		logic       done;
		logic       sampling;
	} atbc_seq_st_t;

	typedef struct packed {
		logic        start;
		logic        armed;
		logic        pwr_en;
		logic        fmt;
		logic [2:0]  div;
		logic        trig_src;
		logic        dly_en;
		logic        pwm_src;
		logic        cmp_hi;
		logic        cmp_lo;
		logic [1:0]  duty_sel;
		logic [7:0]  dly_cfg;
		logic        bg_en;
		logic [7:0]  lo_hb;
		logic [7:0]  lo_lb;
		logic [7:0]  hi_hb;
		logic [7:0]  hi_lb;
		logic [11:0] result;
		logic        eoc_flag;
		logic        cmp_flag;
		logic        eoc_ie;
		logic        cmp_ie;
		atbc_trig_t  trig;
		logic [7:0]  dly;
		logic        pwm_prev;
		logic        go;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		logic        eoc_irq;
		logic        cmp_irq;
	} atbc_top_st_t;

endpackage

// [logic/atbc_conv_seq.sv]
// Converter clock divider and 16-period sample/convert sequencer
`timescale 1ns/1ns
`include "atbc_defs.svh"

module atbc_conv_seq
	import atbc_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       start,
	input  wire logic       pwr_en,
	input  wire logic [2:0] div_sel,
	output logic            busy,
	output logic            done,
	output logic            sampling
);

	atbc_seq_st_t s_r;
	atbc_seq_st_t s_nxt;
	logic [7:0]   lim;
	logic         tick;

	// Divide by 2^div_sel: code 0 is /1, code 7 is /128
	assign lim  = 8'((9'h001 << div_sel) - 9'h001);
	assign tick = (s_r.pre == lim);

	always_comb begin
		s_nxt      = s_r;
		s_nxt.done = 1'b0;
		case (s_r.st)
			SEQ_IDLE: begin
				if (start && pwr_en) begin
					s_nxt.st       = SEQ_RUN;
					s_nxt.pre      = 8'h00;
					s_nxt.per      = 4'h0;
					s_nxt.busy     = 1'b1;
					s_nxt.sampling = 1'b1;
				end
			end
			SEQ_RUN: begin
				if (!pwr_en) begin
					// Power removed: abandon without completion
					s_nxt.st       = SEQ_IDLE;
					s_nxt.busy     = 1'b0;
					s_nxt.sampling = 1'b0;
				end else if (tick) begin
					s_nxt.pre = 8'h00;
					if (s_r.per == `ATBC_LAST_PERIOD) begin
						s_nxt.st       = SEQ_IDLE;
						s_nxt.busy     = 1'b0;
						s_nxt.done     = 1'b1;
						s_nxt.sampling = 1'b0;
					end else begin
						s_nxt.per      = s_r.per + 4'h1;
						s_nxt.sampling = ((s_r.per + 4'h1) < `ATBC_SAMPLE_PERIODS);
					end
				end else begin
					s_nxt.pre = s_r.pre + 8'h01;
				end
			end
			default: begin
				s_nxt.st = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '{st: SEQ_IDLE, pre: 8'h00, per: 4'h0, busy: 1'b0, done: 1'b0,
				sampling: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign busy     = s_r.busy;
	assign done     = s_r.done;
	assign sampling = s_r.sampling;

	// Cycles spent in one conversion, for checking only
	logic [11:0] run_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_cnt <= 12'h000;
		end else if (s_r.st == SEQ_IDLE) begin
			run_cnt <= 12'h001;
		end else begin
			run_cnt <= run_cnt + 12'h001;
		end
	end

	AST_CONV_LENGTH: assert property (@(posedge pclk) disable iff (!presetn)
		s_r.done |-> ($past(run_cnt) == 12'(`ATBC_TOTAL_PERIODS * ({4'h0, lim} + 12'h001))))
		else $error("conversion length is not 16 divided clock periods");

	AST_DIV_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
		(s_r.st == SEQ_RUN) |-> (s_r.pre <= lim))
		else $error("divider count exceeds selected divisor");

endmodule

// [logic/atbc_top.sv]
// Converter trigger, busy/interrupt flags and boundary compare with APB registers
// Operation
// - Bandgap reference output stays low while its enable bit is 0.
// - Low and high boundary register pairs hold values compared with each result.
// - Boundary pairs keep their contents while the converter is disabled.
// - Low boundary unpacks left-justified for format 0, right-justified for format 1.
// - High boundary uses the same format-dependent packing as the low boundary.
// - Trigger source bit picks software start or PWM event as conversion start.
// - Software start bit going 0, 1, 0 begins exactly one conversion.
// - PWM trigger uses period match or the selected channel's duty match.
// - With delay enabled, start waits delay count system clocks after the event.
// - Busy flag rises when a conversion starts and falls when it completes.
// - Completion sets the converter interrupt flag; an enabled flag raises interrupt.
// - Converter clock is system clock divided by 2 to the divider code.
// - Converter runs only while power enable is high; software waits for settling.
// - Each result is checked against the boundaries; a hit raises compare interrupt.
// - Compare mode 00 inside, 01 at/below low, 10 at/above high, 11 either.
// - Delay counting starts on a 0 to 1 change of the selected PWM flag.
// - A conversion takes 4 sampling and 12 converting periods, 16 in total.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "atbc_defs.svh"

module atbc_top
	import atbc_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic              pwm_period_match_flag,
	input  wire logic [2:0]        pwm_duty_match_flag,
	input  wire logic [11:0]       conv_result_in,
	output logic                   bandgap_reference_output,
	output logic                   converter_power_enable,
	output logic                   conv_sampling,
	output logic                   conversion_busy_flag,
	output logic                   conv_done_irq,
	output logic                   compare_irq
);

	atbc_top_st_t s_r;
	atbc_top_st_t s_nxt;
	logic         seq_busy;
	logic         seq_done;
	logic         seq_sampling;

	logic         acc;
	logic         wr;
	logic [7:0]   wb;
	logic [7:0]   a8;
	logic         pwm_flag;
	logic         pwm_rise;
	logic         can_go;
	logic [11:0]  lo_val;
	logic [11:0]  hi_val;
	logic         hit;

	atbc_conv_seq u_seq (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (s_r.go),
		.pwr_en   (s_r.pwr_en),
		.div_sel  (s_r.div),
		.busy     (seq_busy),
		.done     (seq_done),
		.sampling (seq_sampling)
	);

	function automatic logic [11:0] unpack(input logic fmt, input logic [7:0] hb,
		input logic [7:0] lb);
		unpack = fmt ? {hb[3:0], lb} : {hb, lb[7:4]};
	endfunction

	function automatic logic cmp_hit(input logic [1:0] mode, input logic [11:0] v,
		input logic [11:0] lo, input logic [11:0] hi);
		case (mode)
			2'b00:   cmp_hit = (v > lo) && (v < hi);
			2'b01:   cmp_hit = (v <= lo);
			2'b10:   cmp_hit = (v >= hi);
			default: cmp_hit = (v <= lo) || (v >= hi);
		endcase
	endfunction

	assign acc    = psel && penable;
	assign wr     = acc && s_r.pready && pwrite;
	assign wb     = pwdata[7:0];
	assign a8     = 8'(paddr);
	assign lo_val = unpack(s_r.fmt, s_r.lo_hb, s_r.lo_lb);
	assign hi_val = unpack(s_r.fmt, s_r.hi_hb, s_r.hi_lb);
	assign hit    = cmp_hit({s_r.cmp_hi, s_r.cmp_lo}, conv_result_in, lo_val, hi_val);
	// Duty select 11 maps to channel 2
	assign pwm_flag = s_r.pwm_src ? pwm_duty_match_flag[(s_r.duty_sel == 2'b11) ? 2'd2
		: s_r.duty_sel] : pwm_period_match_flag;
	assign pwm_rise = pwm_flag && !s_r.pwm_prev;
	assign can_go   = s_r.pwr_en && !seq_busy && !s_r.go;

	always_comb begin
		s_nxt          = s_r;
		s_nxt.go       = 1'b0;
		s_nxt.pwm_prev = pwm_flag;
		s_nxt.pready   = acc && !s_r.pready;
		s_nxt.pslverr  = 1'b0;
		// Read data is captured in the first access cycle, presented with pready
		if (acc && !s_r.pready) begin
			s_nxt.prdata = 32'h0000_0000;
			case (a8)
				`ATBC_OFF_CTRL0:    s_nxt.prdata[7:4] = {s_r.start, seq_busy, s_r.pwr_en, s_r.fmt};
				`ATBC_OFF_CTRL1:    s_nxt.prdata[2:0] = s_r.div;
				`ATBC_OFF_TRIG:     s_nxt.prdata[7:0] = {s_r.trig_src, s_r.dly_en, s_r.pwm_src,
					s_r.cmp_hi, s_r.cmp_lo, 1'b0, s_r.duty_sel};
				`ATBC_OFF_DELAY:    s_nxt.prdata[7:0] = s_r.dly_cfg;
				`ATBC_OFF_BGREF:    s_nxt.prdata[0] = s_r.bg_en;
				`ATBC_OFF_LO_HB:    s_nxt.prdata[7:0] = s_r.lo_hb;
				`ATBC_OFF_LO_LB:    s_nxt.prdata[7:0] = s_r.lo_lb;
				`ATBC_OFF_HI_HB:    s_nxt.prdata[7:0] = s_r.hi_hb;
				`ATBC_OFF_HI_LB:    s_nxt.prdata[7:0] = s_r.hi_lb;
				`ATBC_OFF_RESULT:   s_nxt.prdata[11:0] = s_r.result;
				`ATBC_OFF_IRQ_STAT: s_nxt.prdata[1:0] = {s_r.cmp_flag, s_r.eoc_flag};
				`ATBC_OFF_IRQ_EN:   s_nxt.prdata[1:0] = {s_r.cmp_ie, s_r.eoc_ie};
				default:            s_nxt.pslverr = 1'b1;
			endcase
		end
		if (wr) begin
			case (a8)
				`ATBC_OFF_CTRL0: begin
					s_nxt.start  = wb[`ATBC_C0_START];
					s_nxt.pwr_en = wb[`ATBC_C0_PWR];
					s_nxt.fmt    = wb[`ATBC_C0_FMT];
				end
				`ATBC_OFF_CTRL1: s_nxt.div = wb[2:0];
				`ATBC_OFF_TRIG: begin
					s_nxt.trig_src = wb[`ATBC_TR_SRC];
					s_nxt.dly_en   = wb[`ATBC_TR_DLY_EN];
					s_nxt.pwm_src  = wb[`ATBC_TR_PWM_SRC];
					s_nxt.cmp_hi   = wb[`ATBC_TR_CMP_HI];
					s_nxt.cmp_lo   = wb[`ATBC_TR_CMP_LO];
					s_nxt.duty_sel = wb[1:0];
				end
				`ATBC_OFF_DELAY:  s_nxt.dly_cfg = wb;
				`ATBC_OFF_BGREF:  s_nxt.bg_en = wb[0];
				// Boundary bytes change only by writes, never by power state
				`ATBC_OFF_LO_HB:  s_nxt.lo_hb = wb;
				`ATBC_OFF_LO_LB:  s_nxt.lo_lb = wb;
				`ATBC_OFF_HI_HB:  s_nxt.hi_hb = wb;
				`ATBC_OFF_HI_LB:  s_nxt.hi_lb = wb;
				`ATBC_OFF_IRQ_EN: begin
					s_nxt.eoc_ie = wb[`ATBC_IRQ_EOC];
					s_nxt.cmp_ie = wb[`ATBC_IRQ_CMP];
				end
				default: begin
				end
			endcase
		end
		// Software start: high arms, following low fires
		if (wr && (a8 == `ATBC_OFF_CTRL0)) begin
			if (wb[`ATBC_C0_START] && !s_r.start) begin
				s_nxt.armed = 1'b1;
			end else if (!wb[`ATBC_C0_START] && s_r.armed) begin
				s_nxt.armed = 1'b0;
				if (!s_r.trig_src && can_go) begin
					s_nxt.go = 1'b1;
				end
			end
		end
		case (s_r.trig)
			TRIG_IDLE: begin
				if (s_r.trig_src && pwm_rise && can_go) begin
					if (s_r.dly_en && (s_r.dly_cfg != 8'h00)) begin
						s_nxt.trig = TRIG_DELAY;
						s_nxt.dly  = s_r.dly_cfg;
					end else begin
						s_nxt.go = 1'b1;
					end
				end
			end
			TRIG_DELAY: begin
				if (!s_r.trig_src || !s_r.pwr_en) begin
					s_nxt.trig = TRIG_IDLE;
				end else if (s_r.dly == 8'h01) begin
					s_nxt.trig = TRIG_IDLE;
					s_nxt.go   = 1'b1;
				end else begin
					s_nxt.dly = s_r.dly - 8'h01;
				end
			end
			default: begin
				s_nxt.trig = TRIG_IDLE;
			end
		endcase
		// Flags: hardware set wins over a write-one clear in the same cycle
		if (seq_done) begin
			s_nxt.result = conv_result_in;
		end
		s_nxt.eoc_flag = seq_done || (s_r.eoc_flag && !(wr && (a8 == `ATBC_OFF_IRQ_STAT)
			&& wb[`ATBC_IRQ_EOC]));
		s_nxt.cmp_flag = (seq_done && hit) || (s_r.cmp_flag && !(wr
			&& (a8 == `ATBC_OFF_IRQ_STAT) && wb[`ATBC_IRQ_CMP]));
		s_nxt.eoc_irq = s_nxt.eoc_flag && s_nxt.eoc_ie;
		s_nxt.cmp_irq = s_nxt.cmp_flag && s_nxt.cmp_ie;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r          <= '0;
			s_r.div      <= `ATBC_RST_DIV;
			s_r.dly_cfg  <= `ATBC_RST_BYTE;
			s_r.trig     <= TRIG_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	logic busy_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= seq_busy;
		end
	end

	assign pready                   = s_r.pready;
	assign prdata                   = s_r.prdata;
	assign pslverr                  = s_r.pslverr;
	assign bandgap_reference_output = s_r.bg_en;
	assign converter_power_enable   = s_r.pwr_en;
	assign conv_sampling            = seq_sampling;
	assign conversion_busy_flag     = seq_busy;
	assign conv_done_irq            = s_r.eoc_irq;
	assign compare_irq              = s_r.cmp_irq;

	// Delay watch, for checking only
	logic [8:0] wcnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wcnt <= 9'h000;
		end else if (s_r.trig == TRIG_IDLE) begin
			wcnt <= 9'h001;
		end else begin
			wcnt <= wcnt + 9'h001;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence sw_low_write;
		wr && (a8 == `ATBC_OFF_CTRL0) && !wb[`ATBC_C0_START];
	endsequence
	sequence sw_fire;
		sw_low_write ##0 (s_r.armed && !s_r.trig_src && can_go);
	endsequence

	AST_BG_LOW: assert property (wr && (a8 == `ATBC_OFF_BGREF) && !wb[0] |=>
		!bandgap_reference_output)
		else $error("bandgap output not low after disable");
	AST_SW_START: assert property (sw_fire |=> s_r.go ##1 conversion_busy_flag)
		else $error("software start pulse did not start a conversion");
	AST_BUSY_SET: assert property ($rose(conversion_busy_flag) |-> $past(s_r.go))
		else $error("busy rose without a start");
	AST_BUSY_CLR: assert property (seq_done |-> !conversion_busy_flag && busy_q)
		else $error("busy not cleared at completion");
	AST_EOC_FLAG: assert property (seq_done |=> s_r.eoc_flag)
		else $error("completion flag not set");
	AST_PWM_NODLY: assert property (s_r.trig == TRIG_IDLE && s_r.trig_src && pwm_rise
		&& can_go && !s_r.dly_en |=> s_r.go)
		else $error("PWM event did not start conversion");
	AST_DELAY_LEN: assert property (s_r.trig == TRIG_DELAY && s_r.dly == 8'h01
		&& s_r.trig_src && s_r.pwr_en |-> wcnt == {1'b0, s_r.dly_cfg})
		else $error("trigger delay length wrong");
	AST_CMP_HIT: assert property (seq_done && hit |=> s_r.cmp_flag)
		else $error("boundary hit not flagged");
	AST_BOUND_KEEP: assert property (!s_r.pwr_en && !wr |=>
		$stable({s_r.lo_hb, s_r.lo_lb, s_r.hi_hb, s_r.hi_lb}))
		else $error("boundary registers changed while disabled");
	AST_BOUND_WRITE: assert property (wr && (a8 == `ATBC_OFF_LO_HB) |=>
		(s_r.lo_hb == $past(wb)))
		else $error("boundary byte write not stored");
	AST_PWR_OFF: assert property (!converter_power_enable |=> !conversion_busy_flag)
		else $error("converter busy while power is off");
	AST_DELAY_START: assert property ($rose(s_r.trig == TRIG_DELAY) |-> $past(pwm_rise))
		else $error("trigger delay started without a rising PWM flag");
	AST_EOC_IRQ: assert property (seq_done && s_r.eoc_ie && !wr |=> conv_done_irq)
		else $error("enabled completion raised no interrupt");
	AST_CMP_IRQ: assert property (seq_done && hit && s_r.cmp_ie && !wr |=> compare_irq)
		else $error("enabled boundary hit raised no interrupt");

endmodule

// [verif/test_adc_trigger_and_boundary_control.sv]
// Self-checking bench for the converter trigger and boundary control block
`timescale 1ns/1ns
`include "atbc_defs.svh"

module test_adc_trigger_and_boundary_control;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        pwm_pf;
	logic [2:0]  pwm_df;
	logic [11:0] res_in;
	logic        bg_out;
	logic        pwr_out;
	logic        smp;
	logic        busy;
	logic        eoc_irq;
	logic        cmp_irq;
	logic [31:0] rd;
	logic        err;
	logic [31:0] bv;
	logic [3:0]  sel;
	int          miscompares;
	int          compares;
	int          lo, hi, r, len, sl, n, base, dn, c;

	atbc_top i_atbc_top (
		.pclk                    (pclk),
		.presetn                 (presetn),
		.psel                    (psel),
		.penable                 (penable),
		.pwrite                  (pwrite),
		.paddr                   (paddr),
		.pwdata                  (pwdata),
		.pready                  (pready),
		.prdata                  (prdata),
		.pslverr                 (pslverr),
		.pwm_period_match_flag   (pwm_pf),
		.pwm_duty_match_flag     (pwm_df),
		.conv_result_in          (res_in),
		.bandgap_reference_output(bg_out),
		.converter_power_enable  (pwr_out),
		.conv_sampling           (smp),
		.conversion_busy_flag    (busy),
		.conv_done_irq           (eoc_irq),
		.compare_irq             (cmp_irq)
	);

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic final_report();
		if (miscompares == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	// One APB transfer, entered at any point, issued after the next rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) begin
			chk("pready", 1, 0);
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Latency from call to busy in n, busy and sampling lengths in len and sl
	task automatic run_conv();
		n = 0;
		len = 0;
		sl = 0;
		while (busy !== 1'b1) begin
			@(posedge pclk);
			n++;
			if (n > 400) begin
				chk("busy rise", 1, 0);
				final_report();
			end
		end
		while (busy === 1'b1) begin
			if (smp === 1'b1) sl++;
			@(posedge pclk);
			len++;
			if (len > 3000) begin
				chk("busy fall", 1, 0);
				final_report();
			end
		end
	endtask

	task automatic sw_conv(input logic f);
		apb(1'b1, `ATBC_OFF_CTRL0, {3'b101, f, 4'h0});
		repeat (4) @(posedge pclk);
		chk("busy on arm", 0, busy);
		apb(1'b1, `ATBC_OFF_CTRL0, {3'b001, f, 4'h0});
		run_conv();
	endtask

	function automatic logic [15:0] pack(input int v, input int f);
		return f ? {4'h0, v[11:0]} : {v[11:0], 4'h0};
	endfunction

	function automatic logic hit(input int m, input int v, input int l, input int h);
		case (m)
			0: return v > l && v < h;
			1: return v <= l;
			2: return v >= h;
			default: return v <= l || v >= h;
		endcase
	endfunction

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		pwm_pf = 1'b0;
		pwm_df = 3'h0;
		res_in = 12'h000;
		miscompares = 0;
		compares = 0;
		void'($urandom(9709));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a <= 'h30; a += 4) begin
			apb(1'b0, 8'(a), 8'h00);
			chk("reset value", 0, rd);
			chk("slave error", a == 'h30, err);
		end
		for (int b = 1; b >= 0; b--) begin
			apb(1'b1, `ATBC_OFF_BGREF, 8'(b));
			repeat (2) @(negedge pclk);
			chk("bandgap out", b, bg_out);
		end
		apb(1'b1, `ATBC_OFF_IRQ_EN, 8'h03);
		for (int m = 0; m < 4; m++) begin
			for (int f = 0; f < 2; f++) begin
				for (int k = 0; k < 3; k++) begin
					lo = $urandom_range(2047, 0);
					hi = $urandom_range(4095, 2048);
					r = k == 0 ? lo : k == 1 ? hi : $urandom_range(4095, 0);
					bv = {pack(lo, f), pack(hi, f)};
					for (int j = 0; j < 4; j++) apb(1'b1, 8'(`ATBC_OFF_LO_HB + 4 * j), bv[31-8*j -: 8]);
					for (int j = 0; j < 4; j++) begin
						apb(1'b0, 8'(`ATBC_OFF_LO_HB + 4 * j), 8'h00);
						chk("boundary", bv[31-8*j -: 8], rd);
					end
					res_in <= 12'(r);
					apb(1'b1, `ATBC_OFF_TRIG, {3'b000, 2'(m), 3'b000});
					apb(1'b1, `ATBC_OFF_IRQ_STAT, 8'h03);
					sw_conv(f[0]);
					chk("busy length", 16, len);
					apb(1'b0, `ATBC_OFF_RESULT, 8'h00);
					chk("result", r, rd);
					apb(1'b0, `ATBC_OFF_IRQ_STAT, 8'h00);
					chk("irq flags", {hit(m, r, lo, hi), 1'b1}, rd);
					@(negedge pclk);
					chk("compare irq", hit(m, r, lo, hi), cmp_irq);
					chk("done irq", 1, eoc_irq);
					chk("power out", 1, pwr_out);
				end
			end
		end
		for (int d = 0; d < 8; d++) begin
			apb(1'b1, `ATBC_OFF_CTRL1, 8'(d));
			sw_conv(1'b0);
			chk("busy length", 16 << d, len);
			chk("sampling length", 4 << d, sl);
		end
		apb(1'b1, `ATBC_OFF_CTRL1, 8'h04);
		apb(1'b1, `ATBC_OFF_CTRL0, 8'h80);
		apb(1'b1, `ATBC_OFF_CTRL0, 8'h00);
		repeat (40) @(posedge pclk);
		chk("busy power off", 0, busy);
		chk("power out", 0, pwr_out);
		for (int j = 0; j < 4; j++) begin
			apb(1'b0, 8'(`ATBC_OFF_LO_HB + 4 * j), 8'h00);
			chk("boundary kept", bv[31-8*j -: 8], rd);
		end
		apb(1'b1, `ATBC_OFF_CTRL0, 8'h20);
		for (int s = 0; s < 5; s++) begin
			for (int dl = 0; dl < 2; dl++) begin
				dn = dl ? $urandom_range(255, 1) : 0;
				c = s == 4 ? 2 : s - 1;
				sel = s == 0 ? 4'h1 : 4'(2 << c);
				apb(1'b1, `ATBC_OFF_DELAY, 8'(dn));
				apb(1'b1, `ATBC_OFF_TRIG, {1'b1, dl[0], s != 0, 3'b000, 2'(s > 0 ? s - 1 : 0)});
				@(posedge pclk);
				{pwm_df, pwm_pf} <= ~sel;
				repeat (300) @(posedge pclk);
				chk("busy on other event", 0, busy);
				{pwm_df, pwm_pf} <= 4'hF;
				run_conv();
				if (dl == 0) base = n;
				chk("trigger latency", base + dn, n);
				{pwm_df, pwm_pf} <= 4'h0;
			end
		end
		final_report();
	end
endmodule
